// File: verilog/eivc_regs.svh
// Purpose: offsets, field positions, reset values, vector numbers
// Assumes: byte addresses on a 32-bit avalon slave
// Notes:   definitions only
`ifndef EIVC_REGS_SVH
`define EIVC_REGS_SVH

`define EIVC_OFS_STAT    5'h00
`define EIVC_OFS_ENAB    5'h04
`define EIVC_OFS_SENS    5'h08
`define EIVC_OFS_SYSC    5'h0c
`define EIVC_OFS_PRIA    5'h10
`define EIVC_OFS_PRIB    5'h14
`define EIVC_OFS_VECT    5'h18

`define EIVC_RST_REG     8'h00
`define EIVC_RST_SYSC    8'h0b
`define EIVC_STAT_MASK   8'h13

`define EIVC_PIN0_BIT    0
`define EIVC_PIN1_BIT    1
`define EIVC_PIN4_BIT    4
`define EIVC_EDGE_BIT    2

`define EIVC_PRI_IRQ0    7
`define EIVC_PRI_IRQ1    6
`define EIVC_PRI_IRQ4    4
`define EIVC_PRI_T0      2
`define EIVC_PRI_T1      1
`define EIVC_PRI_T2      0
`define EIVC_PRI_T3      7
`define EIVC_PRI_T4      6
`define EIVC_PRI_SER     3
`define EIVC_PRI_AD      1

`define EIVC_VEC_NMI     8'h07
`define EIVC_VEC_IRQ0    8'h0c
`define EIVC_VEC_IRQ1    8'h0d
`define EIVC_VEC_IRQ4    8'h10
`define EIVC_VEC_T0      8'h18
`define EIVC_VEC_STRIDE  4
`define EIVC_VEC_SER     8'h34
`define EIVC_VEC_AD      8'h3c

`endif

// File: verilog/eivc_pkg.sv
// Purpose: shared types of the interrupt and vector block
// Assumes: nothing
// Notes:   constants live in eivc_regs.svh
package eivc_pkg;
  typedef enum logic [0:0] {
    EIVC_IDLE = 1'b0,
    EIVC_ACK  = 1'b1
  } eivc_bus_t;
  typedef logic [7:0] eivc_byte_t;
endpackage

// File: verilog/eivc_pin_sense.sv
// Purpose: three-stage pin synchroniser with level and edge events
// Assumes: pin idles high
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ns
module eivc_pin_sense (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic pinIn,
  output logic      pinLvl,
  output logic      fallEv,
  output logic      riseEv
);
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic stable_r;
  logic fall_r;
  logic rise_r;
  logic agree;

  assign agree  = (sync2_r == sync3_r);
  assign pinLvl = stable_r;
  assign fallEv = fall_r;
  assign riseEv = rise_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r  <= 1'b1;
      sync2_r  <= 1'b1;
      sync3_r  <= 1'b1;
      stable_r <= 1'b1;
      fall_r   <= 1'b0;
      rise_r   <= 1'b0;
    end
    else if (ce)
    begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (agree)
        stable_r <= sync3_r;
      fall_r <= stable_r && agree && !sync3_r;
      rise_r <= !stable_r && agree && sync3_r;
    end
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  one_fall_a: assert property (
    (ce && fallEv) ##1 ce |-> !fallEv)
    else $error("falling edge reported twice");
endmodule

// File: verilog/eivc_top.sv
// Purpose: external pin interrupts, vectors and priority select
// Assumes: avalon-mm slave, byte addresses, one wait cycle
// Notes:   cpu masking stays in the core; ackValid marks handling
`timescale 1ns/1ns
`include "eivc_regs.svh"
module eivc_top #(
  parameter int NPERIPH = 20
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        hwStandby,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [2:0]  irqPin_n,
  input  wire logic        nmiPin,
  input  wire logic [19:0] periphReq,
  input  wire logic        ackValid,
  input  wire logic [7:0]  ackVector,
  output logic             reqValid,
  output logic      [7:0]  reqVector,
  output logic      [15:0] reqAddr,
  output logic             reqLevel,
  output logic             reqNmi,
  output logic             wakeReq
);
  localparam int NSRC = NPERIPH + 3;

  eivc_pkg::eivc_bus_t  busSt_r;
  eivc_pkg::eivc_byte_t enab_r;
  eivc_pkg::eivc_byte_t sens_r;
  eivc_pkg::eivc_byte_t sysc_r;
  eivc_pkg::eivc_byte_t priA_r;
  eivc_pkg::eivc_byte_t priB_r;
  logic [2:0]      flag_r;
  logic [2:0]      flag_nxt;
  logic [2:0]      rdOne_r;
  logic [2:0]      enBits;
  logic [2:0]      senBits;
  logic [2:0]      setEv;
  logic [2:0]      clrSw;
  logic [2:0]      clrAck;
  logic [2:0]      ackHit;
  logic [3:0]      pinLvl;
  logic [3:0]      fallEv;
  logic [3:0]      riseEv;
  logic [3:0]      pinsIn;
  logic [NSRC-1:0] maskReq;
  logic [31:0]     rdData_r;
  logic [31:0]     rdMux;
  logic            take;
  logic            takeWr;
  logic            takeRd;
  logic            nmiPend_r;
  logic            nmiSet;
  logic            bestOk;
  logic            bestLvl;
  int              bestIdx;
  logic            reqValid_r;
  logic [7:0]      reqVector_r;
  logic            reqLevel_r;
  logic            reqNmi_r;
  logic            wakeReq_r;

  function automatic logic [7:0] toReg(input logic [2:0] f);
    toReg = `EIVC_RST_REG;
    toReg[`EIVC_PIN0_BIT] = f[0];
    toReg[`EIVC_PIN1_BIT] = f[1];
    toReg[`EIVC_PIN4_BIT] = f[2];
  endfunction

  function automatic logic [2:0] fromReg(input logic [7:0] r);
    fromReg = {r[`EIVC_PIN4_BIT], r[`EIVC_PIN1_BIT],
               r[`EIVC_PIN0_BIT]};
  endfunction

  function automatic logic [7:0] vecOf(input int i);
    int k;
    k = i - 3;
    if (i == 0)
      vecOf = `EIVC_VEC_IRQ0;
    else if (i == 1)
      vecOf = `EIVC_VEC_IRQ1;
    else if (i == 2)
      vecOf = `EIVC_VEC_IRQ4;
    else if (i < 18)
      vecOf = 8'(`EIVC_VEC_T0 + `EIVC_VEC_STRIDE * (k / 3) + k % 3);
    else if (i < 22)
      vecOf = 8'(`EIVC_VEC_SER + i - 18);
    else
      vecOf = `EIVC_VEC_AD;
  endfunction

  function automatic logic lvlOf(input int i,
                                 input logic [7:0] pa,
                                 input logic [7:0] pb);
    if (i == 0)
      lvlOf = pa[`EIVC_PRI_IRQ0];
    else if (i == 1)
      lvlOf = pa[`EIVC_PRI_IRQ1];
    else if (i == 2)
      lvlOf = pa[`EIVC_PRI_IRQ4];
    else if (i < 6)
      lvlOf = pa[`EIVC_PRI_T0];
    else if (i < 9)
      lvlOf = pa[`EIVC_PRI_T1];
    else if (i < 12)
      lvlOf = pa[`EIVC_PRI_T2];
    else if (i < 15)
      lvlOf = pb[`EIVC_PRI_T3];
    else if (i < 18)
      lvlOf = pb[`EIVC_PRI_T4];
    else if (i < 22)
      lvlOf = pb[`EIVC_PRI_SER];
    else
      lvlOf = pb[`EIVC_PRI_AD];
  endfunction

  assign pinsIn = {nmiPin, irqPin_n};

  for (genvar g = 0; g < 4; g++)
  begin : gSense
    eivc_pin_sense uSense (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .pinIn  (pinsIn[g]),
      .pinLvl (pinLvl[g]),
      .fallEv (fallEv[g]),
      .riseEv (riseEv[g])
    );
  end

  // bus slave, one wait cycle per access
  assign take        = (busSt_r == eivc_pkg::EIVC_ACK) && ce;
  assign waitrequest = !take;
  assign takeWr      = take && write && byteenable[0];
  assign takeRd      = take && read;
  assign readdata    = rdData_r;

  always_comb
  begin
    rdMux = 32'h0;
    if (address == `EIVC_OFS_STAT)
      rdMux[7:0] = toReg(flag_r);
    else if (address == `EIVC_OFS_ENAB)
      rdMux[7:0] = enab_r;
    else if (address == `EIVC_OFS_SENS)
      rdMux[7:0] = sens_r;
    else if (address == `EIVC_OFS_SYSC)
      rdMux[7:0] = sysc_r;
    else if (address == `EIVC_OFS_PRIA)
      rdMux[7:0] = priA_r;
    else if (address == `EIVC_OFS_PRIB)
      rdMux[7:0] = priB_r;
    else if (address == `EIVC_OFS_VECT)
      rdMux[10:0] = {reqNmi_r, reqLevel_r, reqValid_r, reqVector_r};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busSt_r  <= eivc_pkg::EIVC_IDLE;
      rdData_r <= 32'h0;
    end
    else if (ce)
    begin
      case (busSt_r)
        eivc_pkg::EIVC_IDLE:
          if (read || write)
          begin
            busSt_r  <= eivc_pkg::EIVC_ACK;
            rdData_r <= rdMux;
          end
        default:
          busSt_r <= eivc_pkg::EIVC_IDLE;
      endcase
    end
  end

  // control registers loaded with reset values by reset and standby
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enab_r <= `EIVC_RST_REG;
      sens_r <= `EIVC_RST_REG;
      sysc_r <= `EIVC_RST_SYSC;
      priA_r <= `EIVC_RST_REG;
      priB_r <= `EIVC_RST_REG;
    end
    else if (ce)
    begin
      if (hwStandby)
      begin
        enab_r <= `EIVC_RST_REG;
        sens_r <= `EIVC_RST_REG;
        sysc_r <= `EIVC_RST_SYSC;
        priA_r <= `EIVC_RST_REG;
        priB_r <= `EIVC_RST_REG;
      end
      else if (takeWr && address == `EIVC_OFS_ENAB)
        enab_r <= writedata[7:0];
      else if (takeWr && address == `EIVC_OFS_SENS)
        sens_r <= writedata[7:0];
      else if (takeWr && address == `EIVC_OFS_SYSC)
        sysc_r <= writedata[7:0];
      else if (takeWr && address == `EIVC_OFS_PRIA)
        priA_r <= writedata[7:0];
      else if (takeWr && address == `EIVC_OFS_PRIB)
        priB_r <= writedata[7:0];
    end
  end

  assign enBits  = fromReg(enab_r);
  assign senBits = fromReg(sens_r);
  assign ackHit  = {ackValid && ackVector == `EIVC_VEC_IRQ4,
                    ackValid && ackVector == `EIVC_VEC_IRQ1,
                    ackValid && ackVector == `EIVC_VEC_IRQ0};

  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      // low level sets in level mode
      // falling edge sets in edge mode
      setEv[k] = senBits[k] ? fallEv[k] : !pinLvl[k];
      // zero write clears a flag read as one
      clrSw[k] = takeWr && address == `EIVC_OFS_STAT &&
                 !writedata[k == 2 ? `EIVC_PIN4_BIT : k] &&
                 rdOne_r[k];
      // level mode clears only with pin high
      clrAck[k] = ackHit[k] && (senBits[k] || pinLvl[k]);
    end
    flag_nxt = setEv | (flag_r & ~(clrSw | clrAck));
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_r <= 3'h0;
    else if (ce)
    begin
      if (hwStandby)
        flag_r <= 3'h0;
      else
        flag_r <= flag_nxt;
    end
  end

  // record of flags seen as one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdOne_r <= 3'h0;
    else if (ce)
    begin
      if (hwStandby)
        rdOne_r <= 3'h0;
      else if (takeRd && address == `EIVC_OFS_STAT)
        rdOne_r <= fromReg(rdData_r[7:0]);
      else
        rdOne_r <= rdOne_r & ~clrSw;
    end
  end

  // nmi edge from the edge select bit
  assign nmiSet = sysc_r[`EIVC_EDGE_BIT] ? riseEv[3] : fallEv[3];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      nmiPend_r <= 1'b0;
    else if (ce)
    begin
      if (hwStandby)
        nmiPend_r <= 1'b0;
      else
        nmiPend_r <= nmiSet || (nmiPend_r &&
                     !(ackValid && ackVector == `EIVC_VEC_NMI));
    end
  end

  // enable bits gate the pin flags
  assign maskReq = {periphReq, flag_r & enBits};

  always_comb
  begin
    bestOk  = 1'b0;
    bestLvl = 1'b0;
    bestIdx = 0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (maskReq[i] &&
          (!bestOk || lvlOf(i, priA_r, priB_r) >= bestLvl))
      begin
        bestOk  = 1'b1;
        bestLvl = lvlOf(i, priA_r, priB_r);
        bestIdx = i;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reqValid_r  <= 1'b0;
      reqVector_r <= 8'h00;
      reqLevel_r  <= 1'b0;
      reqNmi_r    <= 1'b0;
    end
    else if (ce)
    begin
      if (hwStandby)
      begin
        reqValid_r  <= 1'b0;
        reqVector_r <= 8'h00;
        reqLevel_r  <= 1'b0;
        reqNmi_r    <= 1'b0;
      end
      else if (nmiPend_r)
      begin
        reqValid_r  <= 1'b1;
        reqVector_r <= `EIVC_VEC_NMI;
        reqLevel_r  <= 1'b1;
        reqNmi_r    <= 1'b1;
      end
      // timer zero on 24 to 26
      else
      begin
        reqValid_r  <= bestOk;
        reqVector_r <= bestOk ? vecOf(bestIdx) : 8'h00;
        reqLevel_r  <= bestLvl;
        reqNmi_r    <= 1'b0;
      end
    end
  end

  // nmi and first two pins wake
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wakeReq_r <= 1'b0;
    else if (ce)
      wakeReq_r <= !hwStandby &&
                   (nmiPend_r || |(flag_r[1:0] & enBits[1:0]));
  end

  assign reqValid  = reqValid_r;
  assign reqVector = reqVector_r;
  assign reqAddr   = {6'h00, reqVector_r, 2'h0};
  assign reqLevel  = reqLevel_r;
  assign reqNmi    = reqNmi_r;
  assign wakeReq   = wakeReq_r;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence statRdTake;
    takeRd && address == `EIVC_OFS_STAT;
  endsequence

  sequence readOne0;
    statRdTake ##0 readdata[0];
  endsequence

  sequence wrZero0;
    takeWr && address == `EIVC_OFS_STAT && !writedata[0] &&
    !setEv[0] && ce;
  endsequence

  rsvd_zero_a: assert property (
    statRdTake |-> (readdata[7:0] & ~`EIVC_STAT_MASK) == 8'h00)
    else $error("reserved status bit reads one");

  read_clear_a: assert property (
    readOne0 ##[2:3] wrZero0 |=> !flag_r[0])
    else $error("flag not cleared by zero write");

  lvl_set_a: assert property (
    ce && !hwStandby && !senBits[0] && !pinLvl[0] |=> flag_r[0])
    else $error("low level did not set flag");

  edge_set_a: assert property (
    ce && !hwStandby && senBits[0] && fallEv[0] |=> flag_r[0])
    else $error("falling edge did not set flag");

  edge_ack_a: assert property (
    ce && senBits[1] && ackHit[1] && !fallEv[1] |=> !flag_r[1])
    else $error("edge flag kept after handling");

  lvl_ack_a: assert property (
    ce && !senBits[0] && ackHit[0] && pinLvl[0] |=> !flag_r[0])
    else $error("level flag kept with pin high");

  en_gate_a: assert property (
    ce && !enBits[0] |=>
    !(reqValid && reqVector == `EIVC_VEC_IRQ0))
    else $error("disabled pin request presented");

  nmi_first_a: assert property (
    ce && !hwStandby && nmiPend_r |=>
    reqValid && reqNmi && reqVector == `EIVC_VEC_NMI)
    else $error("pending nmi not presented first");

  nmi_edge_a: assert property (
    ce && !hwStandby && !sysc_r[`EIVC_EDGE_BIT] && fallEv[3]
    |=> nmiPend_r)
    else $error("nmi falling edge missed");

  stby_zero_a: assert property (
    ce && hwStandby |=> flag_r == 3'h0 && enab_r == 8'h00 &&
    sens_r == 8'h00)
    else $error("standby left registers set");

  bus_wait_a: assert property (
    (read || write) && waitrequest && ce ##1 ce |-> !waitrequest)
    else $error("bus answer later than one wait");
endmodule

// File: test/eivc_cpu_model.sv
// Purpose: cpu core side, takes requests and pulses handling acks
// Assumes: acks only while autoAck is high
// Notes:   one ack per eight cycles while a request stands
`timescale 1ns/1ns
module eivc_cpu_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       autoAck,
  input  wire logic       reqValid,
  input  wire logic [7:0] reqVector,
  output logic            ackValid,
  output logic      [7:0] ackVector,
  output logic      [7:0] lastVec
);
  logic [2:0] cnt_r;

  // nmi taken regardless of any mask
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r     <= 3'h0;
      ackValid  <= 1'b0;
      ackVector <= 8'h00;
      lastVec   <= 8'h00;
    end
    else if (!autoAck || !reqValid)
    begin
      cnt_r     <= 3'h0;
      ackValid  <= 1'b0;
      ackVector <= ~ackVector;
    end
    else
    begin
      cnt_r    <= cnt_r + 3'h1;
      ackValid <= (cnt_r == 3'h2);
      if (cnt_r == 3'h2)
      begin
        ackVector <= reqVector;
        lastVec   <= reqVector;
      end
      else
        ackVector <= ~ackVector;
    end
  end
endmodule

// File: test/external_irq_and_vector_control_test.sv
// Purpose: self-checking bench of the pin interrupt block
// Assumes: ce and byteenable lane 0 high except in t_gate
// Notes:   cpu model answers requests when autoAck is high
`timescale 1ns/1ns
`include "eivc_regs.svh"
module external_irq_and_vector_control_test;
  logic        clk, arst_n, hwStandby, read, write, nmiPin, autoAck;
  logic        waitrequest, reqValid, reqLevel, reqNmi, wakeReq;
  logic        ackValid, ce;
  logic [3:0]  byteenable;
  logic [31:0] qw;
  logic [4:0]  address;
  logic [31:0] writedata, readdata;
  logic [2:0]  irqPin_n;
  logic [19:0] periphReq;
  logic [7:0]  ackVector, reqVector, lastVec, q;
  logic [15:0] reqAddr;
  int          n_mismatch, checks_done;

  eivc_top u_dut (.clk(clk), .arst_n(arst_n), .ce(ce),
    .hwStandby(hwStandby), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .irqPin_n(irqPin_n), .nmiPin(nmiPin), .periphReq(periphReq),
    .ackValid(ackValid), .ackVector(ackVector), .reqValid(reqValid),
    .reqVector(reqVector), .reqAddr(reqAddr), .reqLevel(reqLevel),
    .reqNmi(reqNmi), .wakeReq(wakeReq));

  eivc_cpu_model u_cpu (.clk(clk), .arst_n(arst_n), .autoAck(autoAck),
    .reqValid(reqValid), .reqVector(reqVector), .ackValid(ackValid),
    .ackVector(ackVector), .lastVec(lastVec));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    read      <= !w;
    write     <= w;
    address   <= a;
    writedata <= {24'h000000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0)
    begin
      n_mismatch++;
      finish_test();
    end
    qw = readdata;
    q  = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string nm, input logic [4:0] a,
                     input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask

  task automatic reqc(input logic v, input logic [7:0] vec,
                      input logic lvl);
    ticks(8);
    chk("reqValid", reqValid, v);
    if (v)
    begin
      chk("reqVector", reqVector, vec);
      chk("reqAddr", reqAddr, {6'h00, vec, 2'h0});
      chk("reqLevel", reqLevel, lvl);
    end
  endtask

  task automatic t_regs();
    rdc("stat", `EIVC_OFS_STAT, 8'h00);
    rdc("enab", `EIVC_OFS_ENAB, 8'h00);
    rdc("sens", `EIVC_OFS_SENS, 8'h00);
    rdc("sysc", `EIVC_OFS_SYSC, 8'h0b);
    bus(1'b1, `EIVC_OFS_ENAB, 8'hec);
    rdc("enab", `EIVC_OFS_ENAB, 8'hec);
    bus(1'b1, `EIVC_OFS_SENS, 8'hec);
    rdc("sens", `EIVC_OFS_SENS, 8'hec);
    bus(1'b1, `EIVC_OFS_STAT, 8'hff);
    rdc("stat", `EIVC_OFS_STAT, 8'h00);
    rdc("unmapped", 5'h1c, 8'h00);
    irqPin_n <= 3'h6;
    reqc(1'b0, 8'h00, 1'b0);
    rdc("stat", `EIVC_OFS_STAT, 8'h01);
    bus(1'b1, `EIVC_OFS_SENS, 8'h00);
    bus(1'b1, `EIVC_OFS_ENAB, 8'h00);
  endtask

  task automatic t_level();
    bus(1'b1, `EIVC_OFS_ENAB, 8'h01);
    reqc(1'b1, `EIVC_VEC_IRQ0, 1'b0);
    irqPin_n <= 3'h7;
    ticks(6);
    autoAck  <= 1'b1;
    reqc(1'b0, 8'h00, 1'b0);
    chk("ackVec", lastVec, `EIVC_VEC_IRQ0);
    autoAck <= 1'b0;
    rdc("stat", `EIVC_OFS_STAT, 8'h00);
  endtask

  task automatic t_edge();
    bus(1'b1, `EIVC_OFS_SENS, 8'h02);
    bus(1'b1, `EIVC_OFS_ENAB, 8'h02);
    irqPin_n <= 3'h5;
    reqc(1'b1, `EIVC_VEC_IRQ1, 1'b0);
    bus(1'b1, `EIVC_OFS_STAT, 8'h00);
    rdc("stat", `EIVC_OFS_STAT, 8'h02);
    bus(1'b1, `EIVC_OFS_STAT, 8'hff);
    rdc("stat", `EIVC_OFS_STAT, 8'h02);
    bus(1'b1, `EIVC_OFS_STAT, 8'h00);
    rdc("stat", `EIVC_OFS_STAT, 8'h00);
    irqPin_n <= 3'h7;
    ticks(6);
    irqPin_n <= 3'h5;
    autoAck  <= 1'b1;
    ticks(8);
    reqc(1'b0, 8'h00, 1'b0);
    autoAck <= 1'b0;
    rdc("stat", `EIVC_OFS_STAT, 8'h00);
    irqPin_n <= 3'h7;
  endtask

  task automatic t_prio();
    bus(1'b1, `EIVC_OFS_SENS, 8'h13);
    bus(1'b1, `EIVC_OFS_ENAB, 8'h13);
    irqPin_n <= 3'h2;
    reqc(1'b1, `EIVC_VEC_IRQ0, 1'b0);
    chk("wake", wakeReq, 1'b1);
    bus(1'b1, `EIVC_OFS_PRIA, 8'h10);
    reqc(1'b1, `EIVC_VEC_IRQ4, 1'b1);
    bus(1'b1, `EIVC_OFS_PRIA, 8'h00);
    rdc("stat", `EIVC_OFS_STAT, 8'h11);
    bus(1'b1, `EIVC_OFS_STAT, 8'h10);
    reqc(1'b1, `EIVC_VEC_IRQ4, 1'b0);
    chk("wake", wakeReq, 1'b0);
    bus(1'b1, `EIVC_OFS_ENAB, 8'h00);
    reqc(1'b0, 8'h00, 1'b0);
    irqPin_n <= 3'h7;
  endtask

  task automatic t_periph();
    periphReq <= 20'h00001;
    reqc(1'b1, `EIVC_VEC_T0, 1'b0);
    periphReq <= 20'h00008;
    reqc(1'b1, 8'h1c, 1'b0);
    periphReq <= 20'h00040;
    bus(1'b1, `EIVC_OFS_PRIA, 8'h01);
    reqc(1'b1, 8'h20, 1'b1);
  endtask

  task automatic t_nmi();
    nmiPin <= 1'b0;
    ticks(8);
    chk("reqNmi", reqNmi, 1'b1);
    reqc(1'b1, `EIVC_VEC_NMI, 1'b1);
    chk("wake", wakeReq, 1'b1);
    bus(1'b0, `EIVC_OFS_VECT, 8'h00);
    chk("vect", qw, {21'h000000, 3'h7, `EIVC_VEC_NMI});
    autoAck <= 1'b1;
    reqc(1'b1, 8'h20, 1'b1);
    chk("ackVec", lastVec, `EIVC_VEC_NMI);
    autoAck <= 1'b0;
    bus(1'b1, `EIVC_OFS_SYSC, 8'h0f);
    nmiPin <= 1'b1;
    reqc(1'b1, `EIVC_VEC_NMI, 1'b1);
    hwStandby <= 1'b1;
    ticks(1);
    hwStandby <= 1'b0;
    periphReq <= 20'h00000;
    rdc("sysc", `EIVC_OFS_SYSC, 8'h0b);
    rdc("pria", `EIVC_OFS_PRIA, 8'h00);
  endtask

  task automatic t_gate();
    byteenable <= 4'h0;
    bus(1'b1, `EIVC_OFS_ENAB, 8'h01);
    byteenable <= 4'h1;
    rdc("enab lane off", `EIVC_OFS_ENAB, 8'h00);
    bus(1'b1, `EIVC_OFS_ENAB, 8'h01);
    ce       <= 1'b0;
    irqPin_n <= 3'h6;
    ticks(8);
    chk("frozen", reqValid, 1'b0);
    ce <= 1'b1;
    reqc(1'b1, `EIVC_VEC_IRQ0, 1'b0);
    irqPin_n <= 3'h7;
  endtask

  initial
  begin
    arst_n    = 1'b0;
    hwStandby = 1'b0;
    read      = 1'b0;
    write     = 1'b0;
    address   = 5'h00;
    writedata = 32'h00000000;
    ce        = 1'b1;
    byteenable = 4'h1;
    irqPin_n  = 3'h7;
    nmiPin    = 1'b1;
    periphReq = 20'h00000;
    autoAck   = 1'b0;
    n_mismatch  = 0;
    checks_done = 0;
    ticks(8);
    arst_n <= 1'b1;
    ticks(1);
    t_regs();
    t_level();
    t_edge();
    t_prio();
    t_periph();
    t_nmi();
    t_gate();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule
